// ===== hdl/upc_pkg.sv
package upc_pkg;
   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_POWER = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_ENABLES = 4'h8;

   // power control layout
   localparam int PWR_ON_BIT = 0;
   localparam int SUSPEND_BIT = 1;
   localparam int BUSY_BIT = 3;
   localparam int GUARD_BIT = 4;
   localparam int ACT_PEND_BIT = 7;

   // event flag / enable layout
   localparam int FLAG_W = 8;
   localparam int BIT_RST_DET = 0;
   localparam int BIT_ERR = 1;
   localparam int BIT_SOF = 2;
   localparam int BIT_TOKEN = 3;
   localparam int BIT_IDLE = 4;
   localparam int BIT_RESUME = 5;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_STALL = 7;
   // error summary is read-only, never cleared by a flag-register write
   localparam logic [FLAG_W-1:0] W1C_MASK = 8'hFD;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [FLAG_W-1:0] ENABLES_RESET = 8'h00;
   localparam logic [23:0] UPPER_ZERO = 24'h000000;

   // timing, clock at 40 MHz
   localparam int CLK_PERIOD_NS = 25;
   localparam int QUIET_TIME_NS = 2500;
   localparam int RESUME_TIME_NS = 2500;
   localparam int IDLE_TIME_MS = 3;
   localparam int QUIET_CYCLES = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESUME_CYCLES = (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_CYCLES =
      (IDLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : upc_pkg

// ===== hdl/upc_line_timer.sv
`timescale 1ns/1ps
module upc_line_timer #(
   parameter int THRESH = 100,
   parameter int CW = $clog2(THRESH + 1)
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // condition to time
   input wire logic level,
   // results
   output logic reached,
   output logic hit
);
   typedef struct packed {
      logic [CW-1:0] count;
      logic reached;
      logic hit;
   } upc_lt_state_t;

   localparam logic [CW-1:0] LAST = CW'(THRESH - 1);

   upc_lt_state_t st_reg;
   upc_lt_state_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.hit = 1'b0;
      if (!level) begin
         st_next.count = '0;
         st_next.reached = 1'b0;
      end else if (!st_reg.reached) begin
         // fires once per unbroken stretch, never again until the level drops
         if (st_reg.count == LAST) begin
            st_next.reached = 1'b1;
            st_next.hit = 1'b1;
         end else begin
            st_next.count = st_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reached = st_reg.reached;
   assign hit = st_reg.hit;
endmodule : upc_line_timer

// ===== hdl/upc_power_irq.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - activity pending flag, read only
// - sleep guard blocks sleep on activity/pending
// - busy while active or not ready
// - suspend gates clock, transceiver low power
// - power off holds outputs, releases pins
// - hardware sets flags, write one clears all but error summary
// - error summary set by enabled errors only
// - stall flag on stall handshake
// - attach flag needs host, quiet, not SE0
// - resume flag after K-state 2.5 us
// - idle flag after 3 ms idle
// - token flag; clearing advances status FIFO
// - frame start flag on SOF or threshold
// - device mode bit 0 is bus reset
// - host mode bit 0 is detach
// - enables mirror flag layout, read/write
// - error interrupt needs its enable
// - unimplemented bits read zero
module upc_power_irq #(
   parameter int IDLE_CYCLES = upc_pkg::IDLE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [upc_pkg::ADDR_W-1:0] addr,
   input wire logic [upc_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [upc_pkg::DATA_W-1:0] rd_data,
   // cable line state, asynchronous
   input wire logic dp_in,
   input wire logic dm_in,
   // protocol engine events and state
   input wire logic host_mode_enable,
   input wire logic bus_activity,
   input wire logic stall_rx,
   input wire logic stall_tx,
   input wire logic token_done,
   input wire logic sof_rx,
   input wire logic sof_threshold,
   input wire logic bus_reset_seen,
   input wire logic attach_seen,
   input wire logic detach_seen,
   input wire logic [7:0] err_cond,
   input wire logic [7:0] err_enable,
   input wire logic err_clear,
   input wire logic core_active,
   input wire logic core_ready,
   // power and system
   output logic module_irq_request,
   output logic sleep_block,
   output logic usb_clk_enable,
   output logic xcvr_low_power,
   output logic pins_owned,
   output logic analog_enable,
   output logic outputs_enable,
   output logic stat_fifo_advance
);
   typedef struct packed {
      logic power_on;
      logic suspend;
      logic guard;
      logic busy;
      logic act_pend;
      logic [upc_pkg::FLAG_W-1:0] flags;
      logic [upc_pkg::FLAG_W-1:0] enables;
      logic irq;
      logic sleep_block;
      logic clk_en;
      logic xcvr_lp;
      logic pins_owned;
      logic analog_en;
      logic outputs_en;
      logic stat_adv;
      logic [upc_pkg::DATA_W-1:0] rdata;
      logic dp_s1;
      logic dp_s2;
      logic dm_s1;
      logic dm_s2;
   } upc_state_t;

   upc_state_t st_reg;
   upc_state_t st_next;

   logic quiet_ok;
   logic resume_hit;
   logic idle_hit;
   logic k_state;
   logic j_state;
   logic se0_state;

   // line decoding uses only the second sync stage
   assign k_state = !st_reg.dp_s2 && st_reg.dm_s2;
   assign j_state = st_reg.dp_s2 && !st_reg.dm_s2;
   assign se0_state = !st_reg.dp_s2 && !st_reg.dm_s2;

   upc_line_timer #(.THRESH(upc_pkg::QUIET_CYCLES)) u_quiet (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(!bus_activity),
      .reached(quiet_ok),
      .hit()
   );

   upc_line_timer #(.THRESH(upc_pkg::RESUME_CYCLES)) u_resume (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(k_state),
      .reached(),
      .hit(resume_hit)
   );

   upc_line_timer #(.THRESH(IDLE_CYCLES)) u_idle (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(j_state),
      .reached(),
      .hit(idle_hit)
   );

   logic wr_power;
   logic wr_flags;
   logic wr_enables;
   logic [upc_pkg::FLAG_W-1:0] set_vec;
   logic [upc_pkg::FLAG_W-1:0] clr_vec;
   logic run;

   assign wr_power = wr_en && (addr == upc_pkg::OFS_POWER);
   assign wr_flags = wr_en && (addr == upc_pkg::OFS_FLAGS);
   assign wr_enables = wr_en && (addr == upc_pkg::OFS_ENABLES);
   // events are only meaningful while the module is powered
   assign run = st_reg.power_on;

   always_comb begin
      set_vec = '0;
      set_vec[upc_pkg::BIT_STALL] = run &&
         ((host_mode_enable && stall_rx) || (!host_mode_enable && stall_tx));
      set_vec[upc_pkg::BIT_ATTACH] = run && host_mode_enable && attach_seen &&
         quiet_ok && !bus_activity && !se0_state;
      // resume must be seen while suspended, so suspend does not gate it
      set_vec[upc_pkg::BIT_RESUME] = run && resume_hit;
      set_vec[upc_pkg::BIT_IDLE] = run && idle_hit;
      set_vec[upc_pkg::BIT_TOKEN] = run && token_done;
      set_vec[upc_pkg::BIT_SOF] = run &&
         ((!host_mode_enable && sof_rx) || (host_mode_enable && sof_threshold));
      set_vec[upc_pkg::BIT_ERR] = run && |(err_cond & err_enable);
      set_vec[upc_pkg::BIT_RST_DET] = run &&
         (host_mode_enable ? detach_seen : bus_reset_seen);
   end

   always_comb begin
      clr_vec = '0;
      if (wr_flags) begin
         clr_vec = wr_data[upc_pkg::FLAG_W-1:0] & upc_pkg::W1C_MASK;
      end
      clr_vec[upc_pkg::BIT_ERR] = err_clear;
   end

   always_comb begin
      st_next = st_reg;
      st_next.dp_s1 = dp_in;
      st_next.dp_s2 = st_reg.dp_s1;
      st_next.dm_s1 = dm_in;
      st_next.dm_s2 = st_reg.dm_s1;

      if (wr_power) begin
         st_next.power_on = wr_data[upc_pkg::PWR_ON_BIT];
         st_next.suspend = wr_data[upc_pkg::SUSPEND_BIT];
         st_next.guard = wr_data[upc_pkg::GUARD_BIT];
      end
      if (wr_enables) begin
         st_next.enables = wr_data[upc_pkg::FLAG_W-1:0];
      end

      // a set in the same cycle as its clear wins
      st_next.flags = (st_reg.flags & ~clr_vec) | set_vec;
      st_next.stat_adv = wr_flags && wr_data[upc_pkg::BIT_TOKEN] &&
         st_reg.flags[upc_pkg::BIT_TOKEN];

      // unmasked flags feed the request, error included only via its enable
      st_next.irq = |(st_reg.flags & st_reg.enables);

      // pending from activity until an interrupt goes out; set wins
      if (bus_activity && run) begin
         st_next.act_pend = 1'b1;
      end else if (st_reg.irq) begin
         st_next.act_pend = 1'b0;
      end

      st_next.busy = st_reg.power_on || core_active || !core_ready;
      st_next.sleep_block = st_reg.guard &&
         (bus_activity || st_reg.act_pend || st_reg.irq);

      st_next.clk_en = st_reg.power_on && !st_reg.suspend;
      st_next.xcvr_lp = !st_reg.power_on || st_reg.suspend;
      st_next.pins_owned = st_reg.power_on;
      st_next.analog_en = st_reg.power_on;
      st_next.outputs_en = st_reg.power_on && !st_reg.suspend;

      // read answer in the next cycle; unused bits stay zero
      st_next.rdata = '0;
      if (rd_en) begin
         unique case (addr)
            upc_pkg::OFS_POWER: begin
               st_next.rdata[upc_pkg::PWR_ON_BIT] = st_reg.power_on;
               st_next.rdata[upc_pkg::SUSPEND_BIT] = st_reg.suspend;
               st_next.rdata[upc_pkg::BUSY_BIT] = st_reg.busy;
               st_next.rdata[upc_pkg::GUARD_BIT] = st_reg.guard;
               st_next.rdata[upc_pkg::ACT_PEND_BIT] = st_reg.act_pend;
            end
            upc_pkg::OFS_FLAGS: begin
               st_next.rdata = {upc_pkg::UPPER_ZERO, st_reg.flags};
            end
            upc_pkg::OFS_ENABLES: begin
               st_next.rdata = {upc_pkg::UPPER_ZERO, st_reg.enables};
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data = st_reg.rdata;
   assign module_irq_request = st_reg.irq;
   assign sleep_block = st_reg.sleep_block;
   assign usb_clk_enable = st_reg.clk_en;
   assign xcvr_low_power = st_reg.xcvr_lp;
   assign pins_owned = st_reg.pins_owned;
   assign analog_enable = st_reg.analog_en;
   assign outputs_enable = st_reg.outputs_en;
   assign stat_fifo_advance = st_reg.stat_adv;

   // checks
   property p_busy_on;
      @(posedge sys_clk) disable iff (rst)
      st_reg.power_on |=> st_reg.busy;
   endproperty
   a_busy_on: assert property (p_busy_on) else $error("busy low while on");

   property p_busy_free;
      @(posedge sys_clk) disable iff (rst)
      (!st_reg.power_on && !core_active && core_ready) |=> !st_reg.busy;
   endproperty
   a_busy_free: assert property (p_busy_free) else $error("busy stuck");

   property p_guard_off;
      @(posedge sys_clk) disable iff (rst)
      !st_reg.guard |=> !sleep_block;
   endproperty
   a_guard_off: assert property (p_guard_off) else $error("sleep blocked");

   property p_guard_on;
      @(posedge sys_clk) disable iff (rst)
      (st_reg.guard && bus_activity) |=> sleep_block;
   endproperty
   a_guard_on: assert property (p_guard_on) else $error("sleep not blocked");

   property p_suspend;
      @(posedge sys_clk) disable iff (rst)
      st_reg.suspend |=> (!usb_clk_enable && xcvr_low_power);
   endproperty
   a_suspend: assert property (p_suspend) else $error("clock not gated");

   property p_off;
      @(posedge sys_clk) disable iff (rst)
      !st_reg.power_on |=> (!pins_owned && !analog_enable && !outputs_enable);
   endproperty
   a_off: assert property (p_off) else $error("outputs active while off");

   property p_w1c;
      @(posedge sys_clk) disable iff (rst)
      (wr_flags && set_vec == '0) |=>
         (st_reg.flags & $past(wr_data[7:0]) & upc_pkg::W1C_MASK) == '0;
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared");

   property p_w0_keep;
      @(posedge sys_clk) disable iff (rst)
      (wr_flags && wr_data[7:0] == 8'h00 && !err_clear) |=>
         (st_reg.flags & $past(st_reg.flags)) == $past(st_reg.flags);
   endproperty
   a_w0_keep: assert property (p_w0_keep) else $error("zero write cleared");

   property p_err_src;
      @(posedge sys_clk) disable iff (rst)
      $rose(st_reg.flags[upc_pkg::BIT_ERR]) |-> $past(|(err_cond & err_enable));
   endproperty
   a_err_src: assert property (p_err_src) else $error("error set unmasked");

   property p_attach;
      @(posedge sys_clk) disable iff (rst)
      $rose(st_reg.flags[upc_pkg::BIT_ATTACH]) |->
         $past(host_mode_enable && quiet_ok && !bus_activity && !se0_state);
   endproperty
   a_attach: assert property (p_attach) else $error("bad attach");

   property p_bit0;
      @(posedge sys_clk) disable iff (rst)
      $rose(st_reg.flags[upc_pkg::BIT_RST_DET]) |->
         $past(host_mode_enable ? detach_seen : bus_reset_seen);
   endproperty
   a_bit0: assert property (p_bit0) else $error("bit 0 wrong source");

   property p_stat_adv;
      @(posedge sys_clk) disable iff (rst)
      (wr_flags && wr_data[upc_pkg::BIT_TOKEN] && st_reg.flags[upc_pkg::BIT_TOKEN])
         |=> stat_fifo_advance ##1 !stat_fifo_advance;
   endproperty
   a_stat_adv: assert property (p_stat_adv) else $error("fifo not advanced");

   property p_irq;
      @(posedge sys_clk) disable iff (rst)
      (|(st_reg.flags & st_reg.enables)) |=> module_irq_request;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_irq_low;
      @(posedge sys_clk) disable iff (rst)
      !(|(st_reg.flags & st_reg.enables)) |=> !module_irq_request;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq spurious");

   property p_rd_zero;
      @(posedge sys_clk) disable iff (rst)
      (rd_en && addr == upc_pkg::OFS_POWER) |=>
         (rd_data[31:8] == 24'h000000 && rd_data[6:5] == 2'h0 && !rd_data[2]);
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("reserved bit set");

   property p_rd_en;
      @(posedge sys_clk) disable iff (rst)
      (rd_en && addr == upc_pkg::OFS_ENABLES) |=>
         rd_data == {24'h000000, $past(st_reg.enables)};
   endproperty
   a_rd_en: assert property (p_rd_en) else $error("enable readback");

   property p_pend;
      @(posedge sys_clk) disable iff (rst)
      (bus_activity && run) |=> st_reg.act_pend;
   endproperty
   a_pend: assert property (p_pend) else $error("pending not set");

   c_irq: cover property (@(posedge sys_clk) disable iff (rst) $rose(module_irq_request));
   c_stall: cover property (@(posedge sys_clk) disable iff (rst)
      $rose(st_reg.flags[upc_pkg::BIT_STALL]));
   c_resume: cover property (@(posedge sys_clk) disable iff (rst)
      st_reg.suspend && $rose(st_reg.flags[upc_pkg::BIT_RESUME]));
   c_fifo: cover property (@(posedge sys_clk) disable iff (rst) stat_fifo_advance);
endmodule : upc_power_irq

// ===== verification/upc_cable_model.sv
`timescale 1ns/1ps
module upc_cable_model (
   // clock
   input wire logic sys_clk,
   // wanted line state: 0 SE0, 1 J, 2 K
   input wire logic [1:0] line_state,
   // cable lines
   output logic dp,
   output logic dm
);
   initial {dp, dm} = 2'h0;
   // lines move a few ns after the edge, out of phase with the sampling clock
   always @(posedge sys_clk) begin
      case (line_state)
         2'h1: {dp, dm} <= #3 2'h2;
         2'h2: {dp, dm} <= #3 2'h1;
         default: {dp, dm} <= #3 2'h0;
      endcase
   end
endmodule : upc_cable_model

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam int IDLE_N = 50;
   localparam logic [3:0] PW = upc_pkg::OFS_POWER;
   localparam logic [3:0] FL = upc_pkg::OFS_FLAGS;
   localparam logic [3:0] EN = upc_pkg::OFS_ENABLES;
   typedef struct packed {
      logic host;
      logic [7:0] ev;
      logic een;
      logic [7:0] ien;
      logic [7:0] exp;
   } upc_row_t;
   // ev: stall_rx, stall_tx, token, sof_rx, sof_thr, bus_reset, detach, error
   upc_row_t rows [15] = '{
      '{1'h1, 8'h01, 1'h0, 8'h80, 8'h80}, '{1'h0, 8'h02, 1'h0, 8'h80, 8'h80},
      '{1'h1, 8'h02, 1'h0, 8'h80, 8'h00}, '{1'h0, 8'h04, 1'h0, 8'h08, 8'h08},
      '{1'h0, 8'h08, 1'h0, 8'h04, 8'h04}, '{1'h1, 8'h08, 1'h0, 8'h04, 8'h00},
      '{1'h1, 8'h10, 1'h0, 8'h04, 8'h04}, '{1'h0, 8'h20, 1'h0, 8'h01, 8'h01},
      '{1'h1, 8'h20, 1'h0, 8'h01, 8'h00}, '{1'h1, 8'h40, 1'h0, 8'h01, 8'h01},
      '{1'h0, 8'h40, 1'h0, 8'h01, 8'h00}, '{1'h0, 8'h80, 1'h1, 8'h02, 8'h02},
      '{1'h0, 8'h80, 1'h0, 8'h02, 8'h00}, '{1'h0, 8'h80, 1'h1, 8'h00, 8'h02},
      '{1'h0, 8'h04, 1'h0, 8'hF7, 8'h08}};
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic host = 1'h0;
   logic [7:0] ev = 8'h00;
   logic [2:0] xp = 3'h0;
   logic een = 1'h0;
   logic cact = 1'h0;
   logic crdy = 1'h1;
   logic [1:0] line = 2'h0;
   logic [31:0] rd_data;
   logic dp, dm, irq, slp, clk_en, lowp, pins, ana, oen, adv;
   int num_errors = 0;
   int samples_checked = 0;

   always #12.5 sys_clk = ~sys_clk;

   upc_cable_model u_cable (.sys_clk(sys_clk), .line_state(line), .dp(dp), .dm(dm));

   upc_power_irq #(.IDLE_CYCLES(IDLE_N)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .dp_in(dp), .dm_in(dm),
      .host_mode_enable(host), .bus_activity(xp[0]), .stall_rx(ev[0]), .stall_tx(ev[1]),
      .token_done(ev[2]), .sof_rx(ev[3]), .sof_threshold(ev[4]),
      .bus_reset_seen(ev[5]), .attach_seen(xp[1]), .detach_seen(ev[6]),
      .err_cond({7'h00, ev[7]}), .err_enable({7'h00, een}), .err_clear(xp[2]),
      .core_active(cact), .core_ready(crdy), .module_irq_request(irq),
      .sleep_block(slp), .usb_clk_enable(clk_en), .xcvr_low_power(lowp),
      .pins_owned(pins), .analog_enable(ana), .outputs_enable(oen),
      .stat_fifo_advance(adv));

   task automatic finish_test;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'h1;
      @(posedge sys_clk);
      wr_en <= 1'h0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge sys_clk);
      rd_en <= 1'h0;
      #1;
      chk(rd_data, e);
   endtask : rd

   // xp: {error clear, attach seen, bus activity}
   task automatic pulse(input logic [7:0] m, input logic [2:0] x);
      @(posedge sys_clk);
      ev <= m;
      xp <= x;
      @(posedge sys_clk);
      ev <= 8'h00;
      xp <= 3'h0;
      repeat (2) @(posedge sys_clk);
   endtask : pulse

   function automatic logic [31:0] outs();
      return {27'h0, clk_en, lowp, pins, ana, oen};
   endfunction : outs

   initial begin
      upc_row_t r;
      repeat (12) @(posedge sys_clk);
      rst <= 1'h0;
      rd(PW, 32'h0);
      rd(FL, 32'h0);
      rd(EN, 32'h0);
      rd(4'hC, 32'h0);
      chk(outs(), 32'h08);
      // the first enables write sets every enable except resume
      wr(EN, 32'hFFFFFFDF);
      rd(EN, 32'hDF);
      wr(PW, 32'hFFFFFFFF);
      rd(PW, 32'h1B);
      chk(outs(), 32'h0E);
      wr(PW, 32'h1);
      rd(PW, 32'h09);
      chk(outs(), 32'h17);
      foreach (rows[i]) begin
         r = rows[i];
         host <= r.host;
         een <= r.een;
         wr(EN, {24'h0, r.ien});
         pulse(r.ev, 3'h0);
         rd(FL, {24'h0, r.exp});
         chk({31'h0, irq}, {31'h0, |(r.exp & r.ien)});
         wr(FL, 32'hFF);
         pulse(8'h00, 3'h4);
         rd(FL, 32'h0);
      end
      host <= 1'h0;
      een <= 1'h1;
      pulse(8'h8C, 3'h0);
      wr(FL, 32'h0);
      rd(FL, 32'h0E);
      wr(FL, 32'h08);
      #1;
      chk({31'h0, adv}, 32'h1);
      wr(FL, 32'hFF);
      rd(FL, 32'h02);
      pulse(8'h00, 3'h4);
      een <= 1'h0;
      rd(FL, 32'h0);
      host <= 1'h1;
      line <= 2'h1;
      wr(EN, 32'h40);
      pulse(8'h00, 3'h3);
      rd(FL, 32'h0);
      repeat (110) @(posedge sys_clk);
      pulse(8'h00, 3'h2);
      rd(FL, 32'h50);
      line <= 2'h0;
      wr(FL, 32'hFF);
      repeat (5) @(posedge sys_clk);
      pulse(8'h00, 3'h2);
      rd(FL, 32'h0);
      wr(PW, 32'h3);
      wr(EN, 32'h20);
      line <= 2'h2;
      repeat (60) @(posedge sys_clk);
      line <= 2'h0;
      rd(FL, 32'h0);
      line <= 2'h2;
      repeat (110) @(posedge sys_clk);
      line <= 2'h0;
      rd(FL, 32'h20);
      chk({31'h0, irq}, 32'h1);
      wr(EN, 32'h0);
      wr(FL, 32'hFF);
      wr(PW, 32'h11);
      pulse(8'h00, 3'h1);
      rd(PW, 32'h99);
      chk({31'h0, slp}, 32'h1);
      wr(PW, 32'h1);
      rd(PW, 32'h89);
      chk({31'h0, slp}, 32'h0);
      wr(EN, 32'h08);
      pulse(8'h04, 3'h0);
      rd(PW, 32'h09);
      wr(FL, 32'hFF);
      cact <= 1'h1;
      wr(PW, 32'h0);
      rd(PW, 32'h08);
      chk(outs(), 32'h08);
      cact <= 1'h0;
      crdy <= 1'h0;
      pulse(8'h04, 3'h0);
      rd(PW, 32'h08);
      // busy stays set while powered off until the core reports ready again
      crdy <= 1'h1;
      rd(PW, 32'h0);
      rd(FL, 32'h0);
      wr(PW, 32'h11);
      @(posedge sys_clk);
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      rd(PW, 32'h0);
      rd(EN, 32'h0);
      finish_test();
   end

   initial begin
      #100us;
      num_errors++;
      finish_test();
   end
endmodule : tb_top
